// ==== amfsr_pkg.sv ====
package amfsr_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CHANNEL_FAULT_FLAGS = 8'h70;
    localparam logic [7:0] OFS_GLOBAL_A = 8'h71;
    localparam logic [7:0] OFS_GLOBAL_B = 8'h72;
    localparam logic [7:0] OFS_WARNING = 8'h73;
    localparam logic [7:0] OFS_MASK_A = 8'h74;
    localparam logic [7:0] OFS_LATCH_MASK_B = 8'h75;
    localparam logic [7:0] OFS_MISC = 8'h76;
    localparam logic [7:0] OFS_CURLIM = 8'h77;
    localparam logic [7:0] OFS_FAULT_CLEAR = 8'h78;

    // ------------------------------------------------------------
    // Reset values and writable-bit masks
    // ------------------------------------------------------------
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_LATCH_MASK_B = 8'hf8;
    localparam logic [7:0] WMASK_MASK_A = 8'hf7;
    localparam logic [7:0] WMASK_FAULT_CLEAR = 8'h7f;
    localparam logic [7:0] RD_UNMAPPED = 8'h00;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    // report_mask_a
    localparam int B_MASK_TSD = 7;
    localparam int B_MASK_CORE_UV = 6;
    localparam int B_MASK_CORE_OV = 5;
    localparam int B_MASK_CLK = 4;
    localparam int B_MASK_PSUP = 2;
    localparam int B_DC_REPORT_MASK = 1;
    localparam int B_OVERCURRENT_REPORT_MASK = 0;
    // latch_and_mask_b
    localparam int B_HOLD_CBCF = 7;
    localparam int B_HOLD_CBCW = 6;
    localparam int B_HOLD_CLK = 5;
    localparam int B_HOLD_TSD = 4;
    localparam int B_HOLD_TW = 3;
    localparam int B_MASK_TW = 2;
    localparam int B_CURRENT_LIMIT_WARN_MASK = 1;
    localparam int B_MASK_CBCF = 0;
    // protection_misc_ctrl
    localparam int B_CLK_DET_HOLD = 7;
    localparam int B_AUTO_REC = 4;
    // current_limit_ctrl
    localparam int B_CL_EN = 2;
    localparam int B_CL_WARN_EN = 1;
    localparam int B_CL_FAULT_EN = 0;
    // fault_clear
    localparam int B_ANALOG_CLR = 7;

    // ------------------------------------------------------------
    // Source vector indices
    // ------------------------------------------------------------
    localparam int NUM_SRC = 21;
    localparam int S_L_DC = 0;
    localparam int S_R_DC = 1;
    localparam int S_L_OC = 2;
    localparam int S_R_OC = 3;
    localparam int S_OTP = 4;
    localparam int S_COEF = 5;
    localparam int S_LOAD = 6;
    localparam int S_CORE_UV = 7;
    localparam int S_CORE_OV = 8;
    localparam int S_CLK = 9;
    localparam int S_PS_OV = 10;
    localparam int S_PS_UV = 11;
    localparam int S_L_CBCF = 12;
    localparam int S_R_CBCF = 13;
    localparam int S_TSD = 14;
    localparam int S_L_CBCW = 15;
    localparam int S_R_CBCW = 16;
    localparam int S_TW1 = 17;
    localparam int S_TW2 = 18;
    localparam int S_TW3 = 19;
    localparam int S_TW4 = 20;

    // ------------------------------------------------------------
    // Pin function select codes
    // ------------------------------------------------------------
    localparam logic [3:0] SEL_WARN_N = 4'h8;
    localparam logic [3:0] SEL_FAULT_N = 4'hb;
    localparam int SEL_W = 4;

endpackage

// ==== amfsr_sync.sv ====
// ------------------------------------------------------------
// Two-stage synchroniser for asynchronous condition levels
// ------------------------------------------------------------
module amfsr_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_r; // First stage, read only by second

    // Both stages clear synchronously
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            meta_r <= '0;
            q <= '0;
        end
        else
        begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule

// ==== amfsr_flag.sv ====
// ------------------------------------------------------------
// Status flag cells: live or held per bit
// ------------------------------------------------------------
module amfsr_flag #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] cond,
    input wire logic [WIDTH-1:0] hold_en,
    input wire logic clr,
    output logic [WIDTH-1:0] flag
);
    // One cell per bit
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_cell
            // Held flags survive until clear; a new event wins over the clear
            always_ff @(posedge clk)
            begin
                if (!rst_n)
                    flag[i] <= 1'b0;
                else if (hold_en[i])
                    flag[i] <= cond[i] | (flag[i] & ~clr);
                else
                    flag[i] <= cond[i];
            end
        end
    endgenerate
endmodule

// ==== amfsr_top.sv ====
module amfsr_top #(
    parameter int NUM_GPIO = 3
) (
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    output logic [7:0] REG_RDATA,
    input wire logic LEFT_DC_FAULT,
    input wire logic RIGHT_DC_FAULT,
    input wire logic LEFT_OVERCURRENT_FAULT,
    input wire logic RIGHT_OVERCURRENT_FAULT,
    input wire logic OTP_CHECK_ERROR,
    input wire logic FILTER_COEF_WRITE_ERROR,
    input wire logic BOOT_LOAD_ERROR,
    input wire logic CORE_SUPPLY_UNDER,
    input wire logic CORE_SUPPLY_OVER,
    input wire logic CLOCK_FAULT,
    input wire logic POWER_SUPPLY_OVERVOLTAGE,
    input wire logic POWER_SUPPLY_UNDERVOLTAGE,
    input wire logic LEFT_CURRENT_LIMIT_HIT,
    input wire logic RIGHT_CURRENT_LIMIT_HIT,
    input wire logic LEFT_CURRENT_LIMIT_NEAR,
    input wire logic RIGHT_CURRENT_LIMIT_NEAR,
    input wire logic THERMAL_SHUTDOWN,
    input wire logic [3:0] THERMAL_WARN_LEVEL,
    input wire logic [NUM_GPIO*amfsr_pkg::SEL_W-1:0] GPIO_SEL,
    output logic [NUM_GPIO-1:0] GPIO_OUT,
    output logic [NUM_GPIO-1:0] GPIO_OE,
    output logic COMBINED_FAULT_OUT_N,
    output logic COMBINED_WARNING_OUT_N,
    output logic CURRENT_LIMIT_ENABLE,
    output logic THERMAL_SHUTDOWN_ACTIVE
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [amfsr_pkg::NUM_SRC-1:0] raw_async; // Unsynchronised conditions
    logic [amfsr_pkg::NUM_SRC-1:0] raw_sync; // Conditions after two flops
    logic [amfsr_pkg::NUM_SRC-1:0] cond; // Qualified conditions
    logic [amfsr_pkg::NUM_SRC-1:0] hold_en; // Per-source hold
    logic [amfsr_pkg::NUM_SRC-1:0] flag; // Status flags
    logic [7:0] mask_a_r; // report_mask_a
    logic [7:0] latch_b_r; // latch_and_mask_b
    logic [7:0] misc_r; // protection_misc_ctrl
    logic [7:0] curlim_r; // current_limit_ctrl
    logic [7:0] fclr_r; // fault_clear reserved bits
    logic clr; // Analog fault clear strobe
    logic fault_any; // Unmasked fault present
    logic warn_any; // Unmasked warning present
    logic [7:0] rd_nxt; // Read mux result
    logic [NUM_GPIO-1:0] gpio_out_nxt;
    logic [NUM_GPIO-1:0] gpio_oe_nxt;

    // ------------------------------------------------------------
    // Condition capture
    // ------------------------------------------------------------
    // Analog comparators are asynchronous to the core clock
    assign raw_async = {THERMAL_WARN_LEVEL, RIGHT_CURRENT_LIMIT_NEAR, LEFT_CURRENT_LIMIT_NEAR,
                        THERMAL_SHUTDOWN, RIGHT_CURRENT_LIMIT_HIT, LEFT_CURRENT_LIMIT_HIT,
                        POWER_SUPPLY_UNDERVOLTAGE, POWER_SUPPLY_OVERVOLTAGE, CLOCK_FAULT,
                        CORE_SUPPLY_OVER, CORE_SUPPLY_UNDER, BOOT_LOAD_ERROR,
                        FILTER_COEF_WRITE_ERROR, OTP_CHECK_ERROR, RIGHT_OVERCURRENT_FAULT,
                        LEFT_OVERCURRENT_FAULT, RIGHT_DC_FAULT, LEFT_DC_FAULT};

    amfsr_sync #(
        .WIDTH(amfsr_pkg::NUM_SRC)
    ) u_sync (
        .clk(CLOCK),
        .rst_n(RST_N),
        .d(raw_async),
        .q(raw_sync)
    );

    // Current-limit events only count while enabled
    always_comb
    begin
        cond = raw_sync;
        if (!(curlim_r[amfsr_pkg::B_CL_EN] && curlim_r[amfsr_pkg::B_CL_FAULT_EN]))
        begin
            cond[amfsr_pkg::S_L_CBCF] = 1'b0;
            cond[amfsr_pkg::S_R_CBCF] = 1'b0;
        end
        if (!(curlim_r[amfsr_pkg::B_CL_EN] && curlim_r[amfsr_pkg::B_CL_WARN_EN]))
        begin
            cond[amfsr_pkg::S_L_CBCW] = 1'b0;
            cond[amfsr_pkg::S_R_CBCW] = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Hold selection
    // ------------------------------------------------------------
    // Analog channel faults always hold; supply and memory errors stay live
    always_comb
    begin
        hold_en = '0;
        hold_en[amfsr_pkg::S_L_DC] = 1'b1;
        hold_en[amfsr_pkg::S_R_DC] = 1'b1;
        hold_en[amfsr_pkg::S_L_OC] = 1'b1;
        hold_en[amfsr_pkg::S_R_OC] = 1'b1;
        hold_en[amfsr_pkg::S_L_CBCF] = latch_b_r[amfsr_pkg::B_HOLD_CBCF];
        hold_en[amfsr_pkg::S_R_CBCF] = latch_b_r[amfsr_pkg::B_HOLD_CBCF];
        hold_en[amfsr_pkg::S_L_CBCW] = latch_b_r[amfsr_pkg::B_HOLD_CBCW];
        hold_en[amfsr_pkg::S_R_CBCW] = latch_b_r[amfsr_pkg::B_HOLD_CBCW];
        // Either control can freeze the clock status
        hold_en[amfsr_pkg::S_CLK] = latch_b_r[amfsr_pkg::B_HOLD_CLK]
            | misc_r[amfsr_pkg::B_CLK_DET_HOLD];
        // Auto recovery overrides the shutdown hold
        hold_en[amfsr_pkg::S_TSD] = latch_b_r[amfsr_pkg::B_HOLD_TSD]
            & ~misc_r[amfsr_pkg::B_AUTO_REC];
        hold_en[amfsr_pkg::S_TW4:amfsr_pkg::S_TW1] = {4{latch_b_r[amfsr_pkg::B_HOLD_TW]}};
    end

    amfsr_flag #(
        .WIDTH(amfsr_pkg::NUM_SRC)
    ) u_flag (
        .clk(CLOCK),
        .rst_n(RST_N),
        .cond(cond),
        .hold_en(hold_en),
        .clr(clr),
        .flag(flag)
    );

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    // Write-one strobe; the bit itself never stores
    assign clr = REG_WR && (REG_ADDR == amfsr_pkg::OFS_FAULT_CLEAR)
        && REG_WDATA[amfsr_pkg::B_ANALOG_CLR];

    // Register writes, one register per offset
    always_ff @(posedge CLOCK)
    begin
        if (!RST_N)
        begin
            mask_a_r <= amfsr_pkg::RST_ZERO;
            latch_b_r <= amfsr_pkg::RST_LATCH_MASK_B;
            misc_r <= amfsr_pkg::RST_ZERO;
            curlim_r <= amfsr_pkg::RST_ZERO;
            fclr_r <= amfsr_pkg::RST_ZERO;
        end
        else if (REG_WR)
        begin
            case (REG_ADDR)
                amfsr_pkg::OFS_MASK_A: mask_a_r <= REG_WDATA & amfsr_pkg::WMASK_MASK_A;
                amfsr_pkg::OFS_LATCH_MASK_B: latch_b_r <= REG_WDATA;
                amfsr_pkg::OFS_MISC: misc_r <= REG_WDATA;
                amfsr_pkg::OFS_CURLIM: curlim_r <= REG_WDATA;
                amfsr_pkg::OFS_FAULT_CLEAR: fclr_r <= REG_WDATA & amfsr_pkg::WMASK_FAULT_CLEAR;
                default: ; // Status and unmapped offsets ignore writes
            endcase
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Reserved status bits read as zero; fault_clear reserved bits read back as written
    always_comb
    begin
        rd_nxt = amfsr_pkg::RD_UNMAPPED;
        case (REG_ADDR)
            amfsr_pkg::OFS_CHANNEL_FAULT_FLAGS:
                rd_nxt = {4'h0, flag[amfsr_pkg::S_L_DC], flag[amfsr_pkg::S_R_DC],
                          flag[amfsr_pkg::S_L_OC], flag[amfsr_pkg::S_R_OC]};
            amfsr_pkg::OFS_GLOBAL_A:
                rd_nxt = {flag[amfsr_pkg::S_OTP], flag[amfsr_pkg::S_COEF],
                          flag[amfsr_pkg::S_LOAD], 2'h0, flag[amfsr_pkg::S_CLK],
                          flag[amfsr_pkg::S_PS_OV], flag[amfsr_pkg::S_PS_UV]};
            amfsr_pkg::OFS_GLOBAL_B:
                rd_nxt = {5'h00, flag[amfsr_pkg::S_R_CBCF], flag[amfsr_pkg::S_L_CBCF],
                          flag[amfsr_pkg::S_TSD]};
            amfsr_pkg::OFS_WARNING:
                rd_nxt = {2'h0, flag[amfsr_pkg::S_L_CBCW], flag[amfsr_pkg::S_R_CBCW],
                          flag[amfsr_pkg::S_TW4:amfsr_pkg::S_TW1]};
            amfsr_pkg::OFS_MASK_A: rd_nxt = mask_a_r;
            amfsr_pkg::OFS_LATCH_MASK_B: rd_nxt = latch_b_r;
            amfsr_pkg::OFS_MISC: rd_nxt = misc_r;
            amfsr_pkg::OFS_CURLIM: rd_nxt = curlim_r;
            amfsr_pkg::OFS_FAULT_CLEAR: rd_nxt = fclr_r; // Clear bit reads zero
            default: rd_nxt = amfsr_pkg::RD_UNMAPPED;
        endcase
    end

    // Read data lags address by one edge
    always_ff @(posedge CLOCK)
    begin
        if (!RST_N)
            REG_RDATA <= amfsr_pkg::RST_ZERO;
        else
            REG_RDATA <= rd_nxt;
    end

    // ------------------------------------------------------------
    // Combined indications
    // ------------------------------------------------------------
    // Masks act only here; the flags above are left untouched
    always_comb
    begin
        fault_any = 1'b0;
        if (!mask_a_r[amfsr_pkg::B_MASK_TSD])
            fault_any = fault_any | flag[amfsr_pkg::S_TSD];
        if (!mask_a_r[amfsr_pkg::B_MASK_CORE_UV])
            fault_any = fault_any | flag[amfsr_pkg::S_CORE_UV];
        if (!mask_a_r[amfsr_pkg::B_MASK_CORE_OV])
            fault_any = fault_any | flag[amfsr_pkg::S_CORE_OV];
        if (!mask_a_r[amfsr_pkg::B_MASK_CLK])
            fault_any = fault_any | flag[amfsr_pkg::S_CLK];
        if (!mask_a_r[amfsr_pkg::B_MASK_PSUP])
            fault_any = fault_any | flag[amfsr_pkg::S_PS_OV] | flag[amfsr_pkg::S_PS_UV];
        if (!mask_a_r[amfsr_pkg::B_DC_REPORT_MASK])
            fault_any = fault_any | flag[amfsr_pkg::S_L_DC] | flag[amfsr_pkg::S_R_DC];
        if (!mask_a_r[amfsr_pkg::B_OVERCURRENT_REPORT_MASK])
            fault_any = fault_any | flag[amfsr_pkg::S_L_OC] | flag[amfsr_pkg::S_R_OC];
        if (!latch_b_r[amfsr_pkg::B_MASK_CBCF])
            fault_any = fault_any | flag[amfsr_pkg::S_L_CBCF] | flag[amfsr_pkg::S_R_CBCF];
    end

    // Warnings: thermal levels and current-limit proximity
    always_comb
    begin
        warn_any = 1'b0;
        if (!latch_b_r[amfsr_pkg::B_MASK_TW])
            warn_any = warn_any | (|flag[amfsr_pkg::S_TW4:amfsr_pkg::S_TW1]);
        if (!latch_b_r[amfsr_pkg::B_CURRENT_LIMIT_WARN_MASK])
            warn_any = warn_any | flag[amfsr_pkg::S_L_CBCW] | flag[amfsr_pkg::S_R_CBCW];
    end

    // Pins are active low and registered to avoid glitches
    always_ff @(posedge CLOCK)
    begin
        if (!RST_N)
        begin
            COMBINED_FAULT_OUT_N <= 1'b1;
            COMBINED_WARNING_OUT_N <= 1'b1;
        end
        else
        begin
            COMBINED_FAULT_OUT_N <= ~fault_any;
            COMBINED_WARNING_OUT_N <= ~warn_any;
        end
    end

    // ------------------------------------------------------------
    // General-purpose pin routing
    // ------------------------------------------------------------
    // Other select codes belong to other blocks; we leave the pin undriven
    genvar g;
    generate
        for (g = 0; g < NUM_GPIO; g++)
        begin : g_pin
            always_comb
            begin
                gpio_out_nxt[g] = 1'b0;
                gpio_oe_nxt[g] = 1'b0;
                if (GPIO_SEL[g*amfsr_pkg::SEL_W +: amfsr_pkg::SEL_W] == amfsr_pkg::SEL_FAULT_N)
                begin
                    gpio_out_nxt[g] = ~fault_any;
                    gpio_oe_nxt[g] = 1'b1;
                end
                else if (GPIO_SEL[g*amfsr_pkg::SEL_W +: amfsr_pkg::SEL_W]
                         == amfsr_pkg::SEL_WARN_N)
                begin
                    gpio_out_nxt[g] = ~warn_any;
                    gpio_oe_nxt[g] = 1'b1;
                end
            end
        end
    endgenerate

    // Select is a same-clock register in the host interface; no sync
    always_ff @(posedge CLOCK)
    begin
        if (!RST_N)
        begin
            GPIO_OUT <= '0;
            GPIO_OE <= '0;
        end
        else
        begin
            GPIO_OUT <= gpio_out_nxt;
            GPIO_OE <= gpio_oe_nxt;
        end
    end

    // ------------------------------------------------------------
    // Side outputs
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK)
    begin
        if (!RST_N)
        begin
            CURRENT_LIMIT_ENABLE <= 1'b0;
            THERMAL_SHUTDOWN_ACTIVE <= 1'b0;
        end
        else
        begin
            CURRENT_LIMIT_ENABLE <= curlim_r[amfsr_pkg::B_CL_EN];
            THERMAL_SHUTDOWN_ACTIVE <= flag[amfsr_pkg::S_TSD];
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    fault_pin_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        fault_any |=> !COMBINED_FAULT_OUT_N)
        else $error("fault pin not asserted");

    warn_pin_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        !warn_any |=> COMBINED_WARNING_OUT_N)
        else $error("warning pin asserted without cause");

    shutdown_read_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        REG_ADDR == amfsr_pkg::OFS_GLOBAL_B |=> REG_RDATA[0] == $past(flag[amfsr_pkg::S_TSD]))
        else $error("thermal shutdown bit misread");

    thermal_hold_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        flag[amfsr_pkg::S_TSD] && latch_b_r[amfsr_pkg::B_HOLD_TSD]
        && !misc_r[amfsr_pkg::B_AUTO_REC] && !clr |=> flag[amfsr_pkg::S_TSD])
        else $error("held shutdown flag dropped");

    auto_recover_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        misc_r[amfsr_pkg::B_AUTO_REC] && !raw_sync[amfsr_pkg::S_TSD]
        && !REG_WR |=> !flag[amfsr_pkg::S_TSD])
        else $error("auto recovery did not release");

    analog_clear_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        clr && !cond[amfsr_pkg::S_L_DC] |=> !flag[amfsr_pkg::S_L_DC])
        else $error("clear left dc flag set");

    limit_gate_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        !curlim_r[amfsr_pkg::B_CL_EN] && !flag[amfsr_pkg::S_L_CBCW] && !REG_WR
        |=> !flag[amfsr_pkg::S_L_CBCW])
        else $error("warning set while limit disabled");

    pin_select_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        GPIO_SEL[(NUM_GPIO-1)*amfsr_pkg::SEL_W +: amfsr_pkg::SEL_W] == amfsr_pkg::SEL_FAULT_N
        |=> GPIO_OE[NUM_GPIO-1] && GPIO_OUT[NUM_GPIO-1] == COMBINED_FAULT_OUT_N)
        else $error("pin not carrying fault");

    masked_flag_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        mask_a_r == amfsr_pkg::WMASK_MASK_A && latch_b_r[amfsr_pkg::B_MASK_CBCF]
        |-> !fault_any)
        else $error("masked fault reached pin");

    misc_write_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        REG_WR && REG_ADDR == amfsr_pkg::OFS_MISC |=> misc_r == $past(REG_WDATA))
        else $error("misc control not stored");

endmodule

// ==== amfsr_host.sv ====
// ------------------------------------------------------------
// Host model: drives the register port like a bus controller
// ------------------------------------------------------------
module amfsr_host (
    input wire logic CLOCK,
    input wire logic [7:0] REG_RDATA,
    output logic [7:0] REG_ADDR,
    output logic [7:0] REG_WDATA,
    output logic REG_WR
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus at time zero
    initial
    begin
        REG_ADDR = 8'h00;
        REG_WDATA = 8'h00;
        REG_WR = 1'b0;
    end

    // One-cycle write strobe; data scrambled after so stale data never matches
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge CLOCK);
        #1;
        REG_ADDR = a;
        REG_WDATA = d;
        REG_WR = 1'b1;
        @(posedge CLOCK);
        #1;
        REG_WR = 1'b0;
        REG_WDATA = ~d;
    endtask

    // Read data is registered: sample two edges after the address
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge CLOCK);
        #1;
        REG_ADDR = a;
        @(posedge CLOCK);
        @(posedge CLOCK);
        #1;
        d = REG_RDATA;
    endtask
endmodule

// ==== amp_fault_status_reporting_tb_top.sv ====
// ------------------------------------------------------------
// Testbench top
// ------------------------------------------------------------
module amp_fault_status_reporting_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic clock = 1'b0; // 20 MHz core clock
    logic rst_n = 1'b0; // Synchronous reset, active low
    logic [20:0] cnd = '0; // Condition levels, package source order
    logic [11:0] gsel = 12'h000; // Pin selects
    logic [7:0] rdata, addr, wdata;
    logic wr, fault_n, warn_n, cl_en, tsd_act;
    logic [2:0] gout, goe;
    int mismatches = 0;
    int compares = 0;
    int seed = 2;
    logic [7:0] v;
    // Register reset table, 0x70..0x78
    logic [7:0] rst_tbl [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hf8, 8'h00, 8'h00, 8'h00};

    always #25 clock = ~clock;

    amfsr_top u_dut (.CLOCK(clock), .RST_N(rst_n), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_WR(wr), .REG_RDATA(rdata), .LEFT_DC_FAULT(cnd[0]), .RIGHT_DC_FAULT(cnd[1]),
        .LEFT_OVERCURRENT_FAULT(cnd[2]), .RIGHT_OVERCURRENT_FAULT(cnd[3]),
        .OTP_CHECK_ERROR(cnd[4]), .FILTER_COEF_WRITE_ERROR(cnd[5]), .BOOT_LOAD_ERROR(cnd[6]),
        .CORE_SUPPLY_UNDER(cnd[7]), .CORE_SUPPLY_OVER(cnd[8]), .CLOCK_FAULT(cnd[9]),
        .POWER_SUPPLY_OVERVOLTAGE(cnd[10]), .POWER_SUPPLY_UNDERVOLTAGE(cnd[11]),
        .LEFT_CURRENT_LIMIT_HIT(cnd[12]), .RIGHT_CURRENT_LIMIT_HIT(cnd[13]),
        .THERMAL_SHUTDOWN(cnd[14]), .LEFT_CURRENT_LIMIT_NEAR(cnd[15]),
        .RIGHT_CURRENT_LIMIT_NEAR(cnd[16]), .THERMAL_WARN_LEVEL(cnd[20:17]), .GPIO_SEL(gsel),
        .GPIO_OUT(gout), .GPIO_OE(goe), .COMBINED_FAULT_OUT_N(fault_n),
        .COMBINED_WARNING_OUT_N(warn_n), .CURRENT_LIMIT_ENABLE(cl_en),
        .THERMAL_SHUTDOWN_ACTIVE(tsd_act));

    amfsr_host u_host (.CLOCK(clock), .REG_RDATA(rdata), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_WR(wr));

    // Single compare point
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Register read and compare
    task automatic rc(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        u_host.rd(a, d);
        chk(d, exp);
    endtask

    // Conditions pass two sync flops; leave margin
    task automatic settle();
        repeat (6) @(posedge clock);
        #1;
    endtask

    // Verdict, also reached by the watchdog
    task automatic final_report();
        $display("mismatches=%0d compares=%0d", mismatches, compares);
        if (mismatches == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Watchdog sized well past the whole sequence
    initial
    begin
        #(50 * 4000);
        mismatches++;
        final_report();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (5) @(posedge clock);
        #1 rst_n = 1'b1;
        for (int i = 0; i < 9; i++) rc(8'(8'h70 + i), rst_tbl[i]);
        rc(8'h50, 8'h00);
        repeat (4)
        begin
            v = 8'($random(seed));
            u_host.wr(8'h76, v);
            rc(8'h76, v);
            u_host.wr(8'h74, v);
            rc(8'h74, v & 8'hf7);
        end
        u_host.wr(8'h78, 8'h7f);
        rc(8'h78, 8'h7f);
        u_host.wr(8'h70, 8'hff);
        rc(8'h70, 8'h00);
        u_host.wr(8'h74, 8'h00);
        u_host.wr(8'h76, 8'h00);
        u_host.wr(8'h77, 8'h07);
        gsel = {4'hb, 4'h8, 4'h0};
        cnd = '1;
        settle();
        chk({7'h0, cl_en}, 8'h01);
        rc(8'h70, 8'h0f);
        rc(8'h71, 8'he7);
        rc(8'h72, 8'h07);
        rc(8'h73, 8'h3f);
        chk({fault_n, warn_n, gout, goe}, 8'h06);
        // Held sources survive the condition, live ones drop
        cnd = '0;
        settle();
        rc(8'h70, 8'h0f);
        rc(8'h71, 8'h04);
        rc(8'h72, 8'h07);
        rc(8'h73, 8'h3f);
        u_host.wr(8'h74, 8'hf7);
        u_host.wr(8'h75, 8'hff);
        settle();
        chk({fault_n, warn_n, gout, goe}, 8'hf6);
        rc(8'h70, 8'h0f);
        u_host.wr(8'h78, 8'h80);
        rc(8'h70, 8'h00);
        rc(8'h72, 8'h00);
        rc(8'h73, 8'h00);
        // Warning refused while its enable is off
        u_host.wr(8'h77, 8'h05);
        cnd[12] = 1'b1;
        cnd[15] = 1'b1;
        settle();
        rc(8'h72, 8'h02);
        rc(8'h73, 8'h00);
        u_host.wr(8'h75, 8'h00);
        u_host.wr(8'h76, 8'h80);
        cnd = '0;
        cnd[9] = 1'b1;
        cnd[14] = 1'b1;
        settle();
        cnd = '0;
        settle();
        rc(8'h71, 8'h04);
        rc(8'h72, 8'h00);
        u_host.wr(8'h75, 8'hf8);
        u_host.wr(8'h76, 8'h10);
        cnd[14] = 1'b1;
        settle();
        chk({7'h0, tsd_act}, 8'h01);
        cnd = '0;
        settle();
        rc(8'h72, 8'h00);
        final_report();
    end
endmodule
